// ---- logic/tlic_ctrl.sv ----
// Two-level interrupt controller for a small 8-bit core.
// Assumes all inputs are synchronous to clk and the core acks at instruction boundaries.
// Function
// - Every source flag sets on its event regardless of its enable bit.
// - Compatibility mode: peripheral sources also need the peripheral group enable.
// - Priority bits matter only while priority mode is enabled.
// - Reset control bit 7 selects priority mode, resets to zero.
// - Peripheral flag bit 4 sets on NVM write completion, resets zero.
// - Peripheral flag bit 2 sets on supply drop; software clears it.
// - Peripheral enable bits 4 and 2 gate NVM and supply drop; reset zero.
// - Peripheral priority bits 4 and 2 select high level; reset one.
// - Unused bits of peripheral flag, enable, priority registers read zero.
// - External input detects rising edge when polarity is one, else falling.
// - Selected edge sets external flag; its enable gates the interrupt.
// - External interrupt wakes the core; vectors afterwards if global enable set.
// - External edge source is always high priority.
// - Timer flag sets on wrap to zero, 8-bit or 16-bit mode.
// - Timer enable is main control bit 5; priority second control bit 2.
// - Change on enabled port pin sets pin flag; own enable and priority.
// - Each pin has change enable; all cleared by power-on reset.
// - Taking an interrupt pushes return PC and copies accumulator, status, bank pointer.
// - High vector 000008h, low vector 000018h; compatibility uses 000008h.
// - Taking an interrupt clears the level's global enable; return sets it.
// - Main control bits 7 and 6: high/low enables, or global/peripheral group.
// - External event to vector latency stays within three to four instruction cycles.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "tlic_defines.svh"

module tlic_ctrl #(
    parameter int PINS = 6
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Register port
    input  wire logic [11:0]       addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [7:0]        rdata,
    // Event sources
    input  wire logic              nvm_write_done,
    input  wire logic              supply_drop_detect,
    input  wire logic              external_edge_irq,
    input  wire logic [15:0]       timer_zero_count,
    input  wire logic              timer_wide,
    input  wire logic [PINS-1:0]   six_pin_port,
    input  wire logic              port_access,
    input  wire logic [4:0]        reset_cause_in,
    // Core side
    input  wire logic              irq_ack,
    input  wire logic              irq_return_op,
    input  wire logic [20:0]       return_pc,
    input  wire logic [7:0]        working_accumulator,
    input  wire logic [7:0]        status_in,
    input  wire logic [7:0]        bank_select_pointer,
    output logic                   irq_req,
    output logic      [20:0]       irq_vector,
    output logic                   wake_req,
    output logic                   stack_push,
    output logic      [20:0]       push_pc,
    output logic      [7:0]        fast_acc,
    output logic      [7:0]        fast_status,
    output logic      [7:0]        fast_bank
);

    logic                  prio_mode_reg;
    logic                  high_level_global_enable_reg;
    logic                  low_level_global_enable_reg;
    logic [2:0]            src_en_reg;
    logic [2:0]            src_flag_reg;
    logic [2:0]            sec_reg;
    logic [1:0]            per_en_reg;
    logic [1:0]            per_flag_reg;
    logic [1:0]            per_prio_reg;
    logic [PINS-1:0]       pin_en_reg;
    logic [PINS-1:0]       pin_latch_reg;
    logic                  ext_prev_reg;
    logic [15:0]           tmr_prev_reg;
    logic                  req_high_reg;
    tlic_pkg::tlic_svc_t   svc_reg;

    logic                  wr_main;
    logic                  wr_sec;
    logic                  wr_per_en;
    logic                  wr_per_flag;
    logic                  wr_per_prio;
    logic                  wr_rst;
    logic                  wr_pin;
    logic                  ext_edge;
    logic                  tmr_wrap;
    logic                  pin_change;
    logic [4:0]            act;
    logic [4:0]            hi;
    logic                  pend_high;
    logic                  pend_low;
    logic                  take;
    logic                  in_high;

    assign wr_main     = wr_stb && addr == `TLIC_MAIN_CTL_ADDR;
    assign wr_sec      = wr_stb && addr == `TLIC_SEC_CTL_ADDR;
    assign wr_per_en   = wr_stb && addr == `TLIC_PER_EN_ADDR;
    assign wr_per_flag = wr_stb && addr == `TLIC_PER_FLAG_ADDR;
    assign wr_per_prio = wr_stb && addr == `TLIC_PER_PRIO_ADDR;
    assign wr_rst      = wr_stb && addr == `TLIC_RST_CTL_ADDR;
    assign wr_pin      = wr_stb && addr == `TLIC_PIN_EN_ADDR;

    // Source events.
    assign ext_edge = sec_reg[2] ? (external_edge_irq && !ext_prev_reg)
                                 : (!external_edge_irq && ext_prev_reg);
    assign tmr_wrap = timer_wide ? (tmr_prev_reg == `TLIC_ALL_ONES && timer_zero_count == 16'h0000)
                                 : (tmr_prev_reg[7:0] == 8'hFF && timer_zero_count[7:0] == 8'h00);
    assign pin_change = |((six_pin_port ^ pin_latch_reg) & pin_en_reg);

    // Active sources: timer, external, pin, nvm, supply drop.
    assign act = {src_en_reg & src_flag_reg, per_en_reg & per_flag_reg};
    // External edge is always high; others follow their priority bit.
    assign hi = {sec_reg[1], 1'b1, sec_reg[0], per_prio_reg};

    always_comb begin
        pend_high = 1'b0;
        pend_low  = 1'b0;
        if (prio_mode_reg) begin
            pend_high = high_level_global_enable_reg && !in_high && |(act & hi);
            pend_low  = high_level_global_enable_reg && low_level_global_enable_reg && svc_reg == tlic_pkg::TLIC_IDLE && |(act & ~hi);
        end else begin
            pend_high = high_level_global_enable_reg && (|act[4:2] || (low_level_global_enable_reg && |act[1:0]));
        end
    end

    assign in_high = svc_reg == tlic_pkg::TLIC_IN_HIGH || svc_reg == tlic_pkg::TLIC_IN_BOTH;
    assign take    = irq_ack && irq_req;

    // Event tracking registers.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_prev_reg <= 1'b1; // A pin held high through reset must not look like a rising edge.
            tmr_prev_reg <= 16'h0000;
        end else begin
            ext_prev_reg <= external_edge_irq;
            tmr_prev_reg <= timer_zero_count;
        end
    end

    // Port value latched on each port access ends the mismatch.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_latch_reg <= '0;
        end else if (port_access) begin
            pin_latch_reg <= six_pin_port;
        end
    end

    // Per-pin change enables.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_en_reg <= '0;
        end else if (wr_pin) begin
            pin_en_reg <= wdata[PINS-1:0];
        end
    end

    // Main control flags; a hardware set wins over a software clear.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src_flag_reg <= 3'h0;
        end else begin
            src_flag_reg <= (wr_main ? wdata[2:0] : src_flag_reg)
                            | {tmr_wrap, ext_edge, pin_change};
        end
    end

    // Main control source enables.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src_en_reg <= 3'h0;
        end else if (wr_main) begin
            src_en_reg <= wdata[5:3];
        end
    end

    // Global enables: ack clears the taken level, return sets the level left.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            high_level_global_enable_reg <= 1'b0;
            low_level_global_enable_reg <= 1'b0;
        end else begin
            if (take && (req_high_reg || !prio_mode_reg)) begin
                high_level_global_enable_reg <= 1'b0;
            end else if (irq_return_op && (in_high || !prio_mode_reg)) begin
                high_level_global_enable_reg <= 1'b1;
            end else if (wr_main) begin
                high_level_global_enable_reg <= wdata[7];
            end
            if (take && !req_high_reg && prio_mode_reg) begin
                low_level_global_enable_reg <= 1'b0;
            end else if (irq_return_op && !in_high && prio_mode_reg
                         && svc_reg != tlic_pkg::TLIC_IDLE) begin
                low_level_global_enable_reg <= 1'b1;
            end else if (wr_main) begin
                low_level_global_enable_reg <= wdata[6];
            end
        end
    end

    // Second control: edge polarity, timer priority, pin priority.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sec_reg <= `TLIC_SEC_RST;
        end else if (wr_sec) begin
            sec_reg <= {wdata[6], wdata[2], wdata[0]};
        end
    end

    // Priority mode control.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prio_mode_reg <= 1'b0;
        end else if (wr_rst) begin
            prio_mode_reg <= wdata[7];
        end
    end

    // Peripheral enables and priorities.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            per_en_reg   <= 2'h0;
            per_prio_reg <= `TLIC_PER_PRIO_RST;
        end else begin
            if (wr_per_en) begin
                per_en_reg <= {wdata[`TLIC_NVM_BIT], wdata[`TLIC_DROP_BIT]};
            end
            if (wr_per_prio) begin
                per_prio_reg <= {wdata[`TLIC_NVM_BIT], wdata[`TLIC_DROP_BIT]};
            end
        end
    end

    // Peripheral flags; events win over software writes.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            per_flag_reg <= 2'h0;
        end else begin
            per_flag_reg <= (wr_per_flag ? {wdata[`TLIC_NVM_BIT], wdata[`TLIC_DROP_BIT]} : per_flag_reg)
                            | {nvm_write_done, supply_drop_detect};
        end
    end

    // Request to the core, and its level.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_req      <= 1'b0;
            req_high_reg <= 1'b0;
            irq_vector   <= `TLIC_VEC_HIGH;
        end else begin
            irq_req      <= (pend_high || pend_low) && !take;
            req_high_reg <= pend_high || !prio_mode_reg;
            irq_vector   <= (pend_high || !prio_mode_reg) ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW;
        end
    end

    // Any enabled flag wakes the core, whatever the global enables.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= |act;
        end
    end

    // Nesting state of handlers in progress.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            svc_reg <= tlic_pkg::TLIC_IDLE;
        end else if (take) begin
            case (svc_reg)
                tlic_pkg::TLIC_IDLE:   svc_reg <= req_high_reg ? tlic_pkg::TLIC_IN_HIGH : tlic_pkg::TLIC_IN_LOW;
                tlic_pkg::TLIC_IN_LOW: svc_reg <= tlic_pkg::TLIC_IN_BOTH;
                default:               svc_reg <= svc_reg;
            endcase
        end else if (irq_return_op) begin
            case (svc_reg)
                tlic_pkg::TLIC_IN_BOTH: svc_reg <= tlic_pkg::TLIC_IN_LOW;
                default:                svc_reg <= tlic_pkg::TLIC_IDLE;
            endcase
        end
    end

    // Context capture on entry.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stack_push  <= 1'b0;
            push_pc     <= 21'h000000;
            fast_acc    <= 8'h00;
            fast_status <= 8'h00;
            fast_bank   <= 8'h00;
        end else begin
            stack_push <= take;
            if (take) begin
                push_pc     <= return_pc;
                fast_acc    <= working_accumulator;
                fast_status <= status_in;
                fast_bank   <= bank_select_pointer;
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd_stb) begin
            if (addr == `TLIC_MAIN_CTL_ADDR) begin
                rdata <= {high_level_global_enable_reg, low_level_global_enable_reg, src_en_reg, src_flag_reg};
            end else if (addr == `TLIC_SEC_CTL_ADDR) begin
                rdata <= {1'b1, sec_reg[2], 3'h0, sec_reg[1], 1'b0, sec_reg[0]};
            end else if (addr == `TLIC_PER_EN_ADDR) begin
                rdata <= {3'h0, per_en_reg[1], 1'b0, per_en_reg[0], 2'h0};
            end else if (addr == `TLIC_PER_FLAG_ADDR) begin
                rdata <= {3'h0, per_flag_reg[1], 1'b0, per_flag_reg[0], 2'h0};
            end else if (addr == `TLIC_PER_PRIO_ADDR) begin
                rdata <= {3'h0, per_prio_reg[1], 1'b0, per_prio_reg[0], 2'h0};
            end else if (addr == `TLIC_RST_CTL_ADDR) begin
                rdata <= {prio_mode_reg, 2'h0, reset_cause_in};
            end else if (addr == `TLIC_PIN_EN_ADDR) begin
                rdata <= 8'(pin_en_reg);
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    property p_ext_flag;
        @(posedge clk) disable iff (!nrst) ext_edge |=> src_flag_reg[1];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("external edge did not set flag");

    property p_rise;
        @(posedge clk) disable iff (!nrst)
            $past(nrst) && sec_reg[2] && external_edge_irq && !$past(external_edge_irq) && !wr_sec |-> ext_edge;
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed");

    property p_nvm_flag;
        @(posedge clk) disable iff (!nrst) nvm_write_done |=> per_flag_reg[1];
    endproperty
    a_nvm_flag: assert property (p_nvm_flag) else $error("nvm flag not set");

    property p_per_zero;
        @(posedge clk) disable iff (!nrst)
            rd_stb && (addr == `TLIC_PER_FLAG_ADDR || addr == `TLIC_PER_EN_ADDR || addr == `TLIC_PER_PRIO_ADDR)
            |=> (rdata & ~`TLIC_PER_MASK) == 8'h00;
    endproperty
    a_per_zero: assert property (p_per_zero) else $error("unused peripheral bits not zero");

    property p_rst_zero;
        @(posedge clk) disable iff (!nrst)
            rd_stb && addr == `TLIC_RST_CTL_ADDR |=> rdata[6:5] == 2'h0 && rdata[4:0] == $past(reset_cause_in);
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("reset control read wrong");

    property p_compat_vec;
        @(posedge clk) disable iff (!nrst)
            !prio_mode_reg && $past(!prio_mode_reg) && irq_req |-> irq_vector == `TLIC_VEC_HIGH;
    endproperty
    a_compat_vec: assert property (p_compat_vec) else $error("compat vector wrong");

    property p_periph_gate;
        @(posedge clk) disable iff (!nrst)
            !prio_mode_reg && !low_level_global_enable_reg && act[4:2] == 3'h0 |=> !irq_req;
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("peripheral not gated");

    property p_ack_clear;
        @(posedge clk) disable iff (!nrst) take && !prio_mode_reg |=> !high_level_global_enable_reg ##1 !irq_req;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("global enable not cleared");

    property p_push;
        @(posedge clk) disable iff (!nrst)
            take |=> stack_push && push_pc == $past(return_pc) && fast_acc == $past(working_accumulator);
    endproperty
    a_push: assert property (p_push) else $error("context not saved");

    property p_ext_high;
        @(posedge clk) disable iff (!nrst)
            prio_mode_reg && act[3] && high_level_global_enable_reg && !in_high && !take |=> irq_req && irq_vector == `TLIC_VEC_HIGH;
    endproperty
    a_ext_high: assert property (p_ext_high) else $error("external not high priority");

    c_high_take: cover property (@(posedge clk) disable iff (!nrst) take && req_high_reg && prio_mode_reg);
    c_low_take: cover property (@(posedge clk) disable iff (!nrst) take && !req_high_reg);
    c_preempt: cover property (@(posedge clk) disable iff (!nrst) svc_reg == tlic_pkg::TLIC_IN_BOTH);
    c_wide_wrap: cover property (@(posedge clk) disable iff (!nrst) tmr_wrap && timer_wide);

endmodule

// ---- logic/tlic_defines.svh ----
// Register offsets, field positions, reset values and vector addresses.
// Assumes a 12-bit register address and 8-bit data.
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH
`define TLIC_PER_EN_ADDR     12'hFA0
`define TLIC_PER_FLAG_ADDR   12'hFA1
`define TLIC_PER_PRIO_ADDR   12'hFA2
`define TLIC_RST_CTL_ADDR    12'hFD0
`define TLIC_MAIN_CTL_ADDR   12'hFF2
`define TLIC_SEC_CTL_ADDR    12'hFF1
`define TLIC_PIN_EN_ADDR     12'hF78
`define TLIC_NVM_BIT         4
`define TLIC_DROP_BIT        2
`define TLIC_PER_MASK        8'h14
`define TLIC_PER_PRIO_RST    2'h3
`define TLIC_SEC_RST         3'h7
`define TLIC_VEC_HIGH        21'h000008
`define TLIC_VEC_LOW         21'h000018
`define TLIC_ALL_ONES        16'hFFFF
`endif

// ---- logic/tlic_pkg.sv ----
// Types shared by the interrupt controller.
// Assumes the defines header is compiled alongside.
package tlic_pkg;
    typedef enum logic [1:0] {
        TLIC_IDLE,
        TLIC_IN_LOW,
        TLIC_IN_HIGH,
        TLIC_IN_BOTH
    } tlic_svc_t;
endpackage

// ---- sim/tb_two_level_interrupt_controller.sv ----
// Self-checking bench for the two-level interrupt controller.
// Assumes the core model acknowledges requests; the bench plays software and the event sources.
`timescale 1ns/1ps
`include "tlic_defines.svh"

module tb_two_level_interrupt_controller;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        nvm_write_done = 1'b0;
    logic        supply_drop_detect = 1'b0;
    logic        external_edge_irq = 1'b0;
    logic [15:0] timer_zero_count = 16'h0000;
    logic        timer_wide = 1'b0;
    logic [5:0]  six_pin_port = 6'h00;
    logic        port_access = 1'b0;
    logic [4:0]  reset_cause_in = 5'h15;
    logic        irq_return_op = 1'b0;
    logic [3:0]  ack_delay = 4'h0;
    logic [7:0]  rdata, working_accumulator, status_in, bank_select_pointer, fast_acc, fast_status, fast_bank;
    logic [20:0] return_pc, irq_vector, push_pc;
    logic        irq_ack, irq_req, wake_req, stack_push;
    int          n_errors = 0;
    int          checks_done = 0;
    int          n_push = 0;
    logic [11:0] map_a [8] = '{12'hFA0, 12'hFA1, 12'hFA2, 12'hFD0, 12'hFF2, 12'hFF1, 12'hF78, 12'hFFF};
    logic [7:0]  map_d [8] = '{8'h00, 8'h00, 8'h14, 8'h15, 8'h00, 8'hC5, 8'h00, 8'h00};

    tlic_ctrl #(.PINS(6)) dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .nvm_write_done(nvm_write_done), .supply_drop_detect(supply_drop_detect),
        .external_edge_irq(external_edge_irq), .timer_zero_count(timer_zero_count), .timer_wide(timer_wide),
        .six_pin_port(six_pin_port), .port_access(port_access), .reset_cause_in(reset_cause_in),
        .irq_ack(irq_ack), .irq_return_op(irq_return_op), .return_pc(return_pc),
        .working_accumulator(working_accumulator), .status_in(status_in), .bank_select_pointer(bank_select_pointer),
        .irq_req(irq_req), .irq_vector(irq_vector), .wake_req(wake_req), .stack_push(stack_push),
        .push_pc(push_pc), .fast_acc(fast_acc), .fast_status(fast_status), .fast_bank(fast_bank));

    tlic_core_model core_u (.clk(clk), .nrst(nrst), .irq_req(irq_req), .ack_delay(ack_delay), .irq_ack(irq_ack),
        .return_pc(return_pc), .working_accumulator(working_accumulator), .status_in(status_in),
        .bank_select_pointer(bank_select_pointer));

    always #5 clk = ~clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        check($sformatf("reg %h", a), 32'(exp), 32'(rdata));
        @(posedge clk);
    endtask

    task automatic pulse_ev(input logic nvm, input logic drop, input logic pa, input logic ret);
        nvm_write_done     <= nvm;
        supply_drop_detect <= drop;
        port_access        <= pa;
        irq_return_op      <= ret;
        @(posedge clk);
        {nvm_write_done, supply_drop_detect, port_access, irq_return_op} <= 4'h0;
        @(posedge clk);
    endtask

    task automatic tick(input logic [15:0] a, input logic [15:0] b);
        timer_zero_count <= a;
        @(posedge clk);
        timer_zero_count <= b;
        repeat (2) @(posedge clk);
    endtask

    task automatic see(input logic req, input logic wake);
        #1;
        check("irq_req", 32'(req), 32'(irq_req));
        check("wake_req", 32'(wake), 32'(wake_req));
        @(posedge clk);
    endtask

    task automatic wait_req(input logic [20:0] vec);
        int k;
        k = 0;
        #1;
        while (irq_req !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 20) begin
            n_errors++;
            $display("[ERR] irq_req expected 1 seen %b", irq_req);
            report_and_stop();
        end else begin
            check("irq_vector", 32'(vec), 32'(irq_vector));
        end
        repeat (8) @(posedge clk);
    endtask

    // Every context save is compared with what the core model offered at that acknowledge.
    always @(posedge clk) begin
        if (stack_push === 1'b1) begin
            check("push_pc", 32'(21'h001000 + n_push), 32'(push_pc));
            check("fast", {8'h00, 8'(8'hA0 + n_push), 8'(8'h50 + n_push), 8'(8'h30 + n_push)},
                  {8'h00, fast_acc, fast_status, fast_bank});
            n_push++;
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd(map_a[i], map_d[i]);
        end
        wr(12'hFA0, 8'hFF);
        rd(12'hFA0, 8'h14);
        wr(12'hFA2, 8'hFF);
        rd(12'hFA2, 8'h14);
        pulse_ev(1'b1, 1'b0, 1'b0, 1'b0);
        rd(12'hFA1, 8'h10);
        pulse_ev(1'b0, 1'b1, 1'b0, 1'b0);
        rd(12'hFA1, 8'h14);
        see(1'b0, 1'b1);
        wr(12'hFA1, 8'h00);
        rd(12'hFA1, 8'h00);
        // Compatibility mode with a slow core: low priority bit must be ignored.
        wr(12'hFA0, 8'h10);
        wr(12'hFA2, 8'h00);
        ack_delay <= 4'h5;
        wr(12'hFF2, 8'h80);
        pulse_ev(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (3) see(1'b0, 1'b1);
        wr(12'hFF2, 8'hC0);
        wait_req(`TLIC_VEC_HIGH);
        rd(12'hFF2, 8'h40);
        wr(12'hFA1, 8'h00);
        pulse_ev(1'b0, 1'b0, 1'b0, 1'b1);
        rd(12'hFF2, 8'hC0);
        // Priority mode: low handler preempted by the external edge.
        ack_delay <= 4'h0;
        wr(12'hFD0, 8'h80);
        rd(12'hFD0, 8'h95);
        wr(12'hFF2, 8'hD0);
        pulse_ev(1'b1, 1'b0, 1'b0, 1'b0);
        wait_req(`TLIC_VEC_LOW);
        rd(12'hFF2, 8'h90);
        external_edge_irq <= 1'b1;
        wait_req(`TLIC_VEC_HIGH);
        rd(12'hFF2, 8'h12);
        wr(12'hFA1, 8'h00);
        wr(12'hFF2, 8'h10);
        pulse_ev(1'b0, 1'b0, 1'b0, 1'b1);
        rd(12'hFF2, 8'h90);
        pulse_ev(1'b0, 1'b0, 1'b0, 1'b1);
        rd(12'hFF2, 8'hD0);
        // Falling edge selected; enable gates, wake needs no global enable.
        wr(12'hFD0, 8'h00);
        wr(12'hFF1, 8'h05);
        rd(12'hFF1, 8'h85);
        wr(12'hFF2, 8'h00);
        external_edge_irq <= 1'b0;
        repeat (2) @(posedge clk);
        rd(12'hFF2, 8'h02);
        see(1'b0, 1'b0);
        wr(12'hFF2, 8'h00);
        external_edge_irq <= 1'b1;
        repeat (2) @(posedge clk);
        rd(12'hFF2, 8'h00);
        external_edge_irq <= 1'b0;
        repeat (2) @(posedge clk);
        wr(12'hFF2, 8'h12);
        see(1'b0, 1'b1);
        wr(12'hFF2, 8'h92);
        wait_req(`TLIC_VEC_HIGH);
        wr(12'hFF2, 8'h00);
        pulse_ev(1'b0, 1'b0, 1'b0, 1'b1);
        // Timer wrap in both widths, then low priority in priority mode.
        wr(12'hFF2, 8'h00);
        tick(16'h00FF, 16'h0000);
        rd(12'hFF2, 8'h04);
        wr(12'hFF2, 8'h00);
        timer_wide <= 1'b1;
        tick(16'h00FF, 16'h0100);
        rd(12'hFF2, 8'h00);
        tick(16'hFFFF, 16'h0000);
        rd(12'hFF2, 8'h04);
        wr(12'hFF1, 8'h01);
        wr(12'hFD0, 8'h80);
        wr(12'hFF2, 8'hE4);
        wait_req(`TLIC_VEC_LOW);
        wr(12'hFF2, 8'h00);
        pulse_ev(1'b0, 1'b0, 1'b0, 1'b1);
        // Pin change on enabled pins only.
        wr(12'hF78, 8'hFF);
        rd(12'hF78, 8'h3F);
        wr(12'hF78, 8'h01);
        pulse_ev(1'b0, 1'b0, 1'b1, 1'b0);
        six_pin_port <= 6'h02;
        repeat (2) @(posedge clk);
        rd(12'hFF2, 8'h40);
        six_pin_port <= 6'h03;
        repeat (2) @(posedge clk);
        rd(12'hFF2, 8'h41);
        pulse_ev(1'b0, 1'b0, 1'b1, 1'b0);
        wr(12'hFF2, 8'h00);
        rd(12'hFF2, 8'h00);
        check("pushes", 32'h5, 32'(n_push));
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(12'hF78, 8'h00);
        rd(12'hFD0, 8'h15);
        report_and_stop();
    end
endmodule

// ---- sim/tlic_core_model.sv ----
// Behavioural processor core on the far side of the interrupt controller.
// Assumes irq_req is a registered level and answers it with a one-cycle acknowledge.
`timescale 1ns/1ps

module tlic_core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Request and answer
    input  wire logic        irq_req,
    input  wire logic [3:0]  ack_delay,
    output logic             irq_ack,
    // Context handed over at acknowledge
    output logic [20:0]      return_pc,
    output logic [7:0]       working_accumulator,
    output logic [7:0]       status_in,
    output logic [7:0]       bank_select_pointer
);
    logic [3:0] wait_cnt;
    logic [3:0] n_taken;

    // The acknowledge waits ack_delay cycles of a standing request, so slow cores are covered too.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_ack  <= 1'b0;
            wait_cnt <= 4'h0;
            n_taken  <= 4'h0;
        end else if (irq_ack) begin
            irq_ack  <= 1'b0;
            wait_cnt <= 4'h0;
            n_taken  <= n_taken + 4'h1;
        end else if (irq_req && wait_cnt == ack_delay) begin
            irq_ack <= 1'b1;
        end else if (irq_req) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            wait_cnt <= 4'h0;
        end
    end

    // Each acknowledge hands over a distinct context, as a fast return relies on the saved copy.
    assign return_pc           = 21'h001000 + {17'h00000, n_taken};
    assign working_accumulator = 8'hA0 + {4'h0, n_taken};
    assign status_in           = 8'h50 + {4'h0, n_taken};
    assign bank_select_pointer = 8'h30 + {4'h0, n_taken};
endmodule
